/* File: core/port_mux_pkg.sv */
`default_nettype none
package port_mux_pkg;

  // ******************************************************************
  // Port widths
  // ******************************************************************
  localparam int unsigned PORT_A_WIDTH = 12;
  localparam int unsigned PORT_B_WIDTH = 8;
  localparam int unsigned PORT_C_WIDTH = 7;

  // ******************************************************************
  // Reset values: every pin starts on its peripheral function
  // ******************************************************************
  localparam logic [11:0] PORT_A_PER_RESET = 12'hFFF;
  localparam logic [7:0]  PORT_B_PER_RESET = 8'hFF;
  localparam logic [6:0]  PORT_C_PER_RESET = 7'h7F;
  localparam logic [11:0] PORT_A_PUR_RESET = 12'hFFF;
  localparam logic [7:0]  PORT_B_PUR_RESET = 8'hFF;
  // Crystal pins (bits 0 and 1) come up without pull-ups
  localparam logic [6:0]  PORT_C_PUR_RESET = 7'h7C;

  // ******************************************************************
  // Field positions
  // ******************************************************************
  localparam int unsigned A_PWM_LO   = 0;
  localparam int unsigned A_SPI1_LO  = 2;
  localparam int unsigned A_FAULT_LO = 6;
  localparam int unsigned A_SENSE_LO = 9;
  localparam int unsigned B_SPI0_LO  = 0;
  localparam int unsigned B_DEC_LO   = 4;
  localparam int unsigned C_CRYSTAL_IN  = 0;
  localparam int unsigned C_CRYSTAL_OUT = 1;
  localparam int unsigned C_CAN_RX   = 2;
  localparam int unsigned C_CAN_TX   = 3;
  localparam int unsigned C_TMR3     = 4;
  localparam int unsigned C_TMR1     = 5;
  localparam int unsigned C_TMR0     = 6;

  // ******************************************************************
  // Pin function select reset values (0 = primary peripheral)
  // ******************************************************************
  localparam logic [3:0] A_SEL_RESET   = 4'h0;
  localparam logic [1:0] C_SEL_RESET   = 2'h0;
  localparam logic       DEC_SEL_RESET = 1'b0;

  typedef struct packed {
    logic [11:0] data;
    logic [11:0] dir;
    logic [11:0] per;
    logic [11:0] pur;
  } port_a_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] per;
    logic [7:0] pur;
  } port_b_cfg_t;

  typedef struct packed {
    logic [6:0] data;
    logic [6:0] dir;
    logic [6:0] per;
    logic [6:0] pur;
  } port_c_cfg_t;

  typedef struct packed {
    logic [3:0] a_spi1;
    logic [1:0] c_sci0;
    logic       b_timer_a;
  } pin_sel_t;

endpackage
`default_nettype wire

/* File: core/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;

  always_comb
  begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o  <= '0;
    end
    else
    begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule
`default_nettype wire

/* File: core/port_pin_mux.sv */
// How it works
// - Three ports A, B and C of 12, 8 and 7 bits each reach a package pin per bit.
// - Each port register holds only as many bits as its port is wide.
// - After reset every pin carries its peripheral function.
// - Pull-up and peripheral-enable reset values are set per port and per pin.
// - Port A bits 0-5 are PWM outputs, 6-8 fault inputs, 9-11 current-sense inputs.
// - Port B bits 0-3 are SPI0 select, MISO, MOSI, clock; 4-7 decoder home, index, B, A.
// - A per-pin select picks PWM or SPI1 on port A bits 2 to 5.
// - The decoder control bit picks decoder inputs or timer A channels 3..0 on port B 4-7.
// - A per-pin select picks timer C channels 1/0 or serial receive/transmit on port C 5-6.
// - Port C bits 0 and 1 are the crystal pins and their pull-ups start disabled.
// - Port C bits 2 to 4 are CAN receive, CAN transmit and timer C channel 3.
`timescale 1ns/1ps
`default_nettype none
module port_pin_mux
  import port_mux_pkg::*;
#(
  parameter int unsigned AW = port_mux_pkg::PORT_A_WIDTH,
  parameter int unsigned BW = port_mux_pkg::PORT_B_WIDTH,
  parameter int unsigned CW = port_mux_pkg::PORT_C_WIDTH
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // Software writes
  input  wire port_mux_pkg::port_a_cfg_t a_cfg_i,
  input  wire port_mux_pkg::port_b_cfg_t b_cfg_i,
  input  wire port_mux_pkg::port_c_cfg_t c_cfg_i,
  input  wire port_mux_pkg::pin_sel_t    sel_i,
  input  wire logic                      a_wr_i,
  input  wire logic                      b_wr_i,
  input  wire logic                      c_wr_i,
  input  wire logic                      sel_wr_i,
  // Register readback
  output port_mux_pkg::port_a_cfg_t      a_cfg_o,
  output port_mux_pkg::port_b_cfg_t      b_cfg_o,
  output port_mux_pkg::port_c_cfg_t      c_cfg_o,
  output port_mux_pkg::pin_sel_t         sel_o,
  output logic [AW-1:0]                  a_in_o,
  output logic [BW-1:0]                  b_in_o,
  output logic [CW-1:0]                  c_in_o,
  // Peripheral side
  input  wire logic [5:0]                pwm_output_line_i,
  input  wire logic [3:0]                spi1_out_i,
  input  wire logic [3:0]                spi1_oe_n_i,
  input  wire logic [3:0]                spi0_out_i,
  input  wire logic [3:0]                spi0_oe_n_i,
  input  wire logic [3:0]                timer_a_channel_out_i,
  input  wire logic [3:0]                timer_a_channel_oe_n_i,
  input  wire logic [2:0]                timer_c_channel_out_i,
  input  wire logic [2:0]                timer_c_channel_oe_n_i,
  input  wire logic                      can_tx_i,
  input  wire logic                      serial_transmit_line_i,
  output logic [2:0]                     pwm_fault_input_o,
  output logic [2:0]                     current_sense_input_o,
  output logic [3:0]                     spi1_in_o,
  output logic [3:0]                     spi0_in_o,
  output logic                           decoder_home_input_o,
  output logic                           decoder_index_input_o,
  output logic                           decoder_phase_b_input_o,
  output logic                           decoder_phase_a_input_o,
  output logic [3:0]                     timer_a_channel_in_o,
  output logic [2:0]                     timer_c_channel_in_o,
  output logic                           can_rx_o,
  output logic                           serial_receive_line_o,
  output logic                           crystal_enable_o,
  // Pins
  input  wire logic [AW-1:0]             a_pin_i,
  input  wire logic [BW-1:0]             b_pin_i,
  input  wire logic [CW-1:0]             c_pin_i,
  output logic [AW-1:0]                  a_pin_o,
  output logic [AW-1:0]                  a_pin_oe_n_o,
  output logic [AW-1:0]                  a_pullup_o,
  output logic [BW-1:0]                  b_pin_o,
  output logic [BW-1:0]                  b_pin_oe_n_o,
  output logic [BW-1:0]                  b_pullup_o,
  output logic [CW-1:0]                  c_pin_o,
  output logic [CW-1:0]                  c_pin_oe_n_o,
  output logic [CW-1:0]                  c_pullup_o
);

  // ******************************************************************
  // Configuration registers
  // ******************************************************************
  port_a_cfg_t a_cfg;
  port_b_cfg_t b_cfg;
  port_c_cfg_t c_cfg;
  pin_sel_t    sel;
  port_a_cfg_t next_a_cfg;
  port_b_cfg_t next_b_cfg;
  port_c_cfg_t next_c_cfg;
  pin_sel_t    next_sel;

  always_comb
  begin
    next_a_cfg = a_wr_i ? a_cfg_i : a_cfg;
    next_b_cfg = b_wr_i ? b_cfg_i : b_cfg;
    next_c_cfg = c_wr_i ? c_cfg_i : c_cfg;
    next_sel   = sel_wr_i ? sel_i : sel;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      a_cfg <= '{data: 12'h000, dir: 12'h000, per: PORT_A_PER_RESET, pur: PORT_A_PUR_RESET};
      b_cfg <= '{data: 8'h00, dir: 8'h00, per: PORT_B_PER_RESET, pur: PORT_B_PUR_RESET};
      c_cfg <= '{data: 7'h00, dir: 7'h00, per: PORT_C_PER_RESET, pur: PORT_C_PUR_RESET};
      sel   <= '{a_spi1: A_SEL_RESET, c_sci0: C_SEL_RESET, b_timer_a: DEC_SEL_RESET};
    end
    else
    begin
      a_cfg <= next_a_cfg;
      b_cfg <= next_b_cfg;
      c_cfg <= next_c_cfg;
      sel   <= next_sel;
    end
  end

  assign a_cfg_o = a_cfg;
  assign b_cfg_o = b_cfg;
  assign c_cfg_o = c_cfg;
  assign sel_o   = sel;
  assign a_pullup_o = a_cfg.pur;
  assign b_pullup_o = b_cfg.pur;
  assign c_pullup_o = c_cfg.pur;
  // Oscillator stays on while both crystal pins belong to it
  assign crystal_enable_o = c_cfg.per[C_CRYSTAL_IN] & c_cfg.per[C_CRYSTAL_OUT];

  // ******************************************************************
  // Pin input synchronisers
  // ******************************************************************
  logic [AW-1:0] a_sync;
  logic [BW-1:0] b_sync;
  logic [CW-1:0] c_sync;

  pin_sync #(.WIDTH(AW)) u_sync_a (.clk_i(clk_i), .rst_i(rst_i), .d_i(a_pin_i), .q_o(a_sync));
  pin_sync #(.WIDTH(BW)) u_sync_b (.clk_i(clk_i), .rst_i(rst_i), .d_i(b_pin_i), .q_o(b_sync));
  pin_sync #(.WIDTH(CW)) u_sync_c (.clk_i(clk_i), .rst_i(rst_i), .d_i(c_pin_i), .q_o(c_sync));

  assign a_in_o = a_sync;
  assign b_in_o = b_sync;
  assign c_in_o = c_sync;

  // ******************************************************************
  // Peripheral routing, registered so pins come from flip-flops
  // ******************************************************************
  logic [AW-1:0] per_a_out, per_a_oe_n;
  logic [BW-1:0] per_b_out, per_b_oe_n;
  logic [CW-1:0] per_c_out, per_c_oe_n;
  logic [AW-1:0] next_a_pin, next_a_oe_n;
  logic [BW-1:0] next_b_pin, next_b_oe_n;
  logic [CW-1:0] next_c_pin, next_c_oe_n;

  always_comb
  begin
    // Port A: PWM outputs low six, inputs above
    per_a_out  = '0;
    per_a_oe_n = '1;
    per_a_out[A_PWM_LO +: 6]  = pwm_output_line_i;
    per_a_oe_n[A_PWM_LO +: 6] = 6'h00;
    for (int i = 0; i < 4; i++)
    begin
      if (sel.a_spi1[i])
      begin
        per_a_out[A_SPI1_LO + i]  = spi1_out_i[i];
        per_a_oe_n[A_SPI1_LO + i] = spi1_oe_n_i[i];
      end
    end
    // Port B
    per_b_out  = '0;
    per_b_oe_n = '1;
    per_b_out[B_SPI0_LO +: 4]  = spi0_out_i;
    per_b_oe_n[B_SPI0_LO +: 4] = spi0_oe_n_i;
    if (sel.b_timer_a)
    begin
      for (int i = 0; i < 4; i++)
      begin
        per_b_out[B_DEC_LO + i]  = timer_a_channel_out_i[3 - i];
        per_b_oe_n[B_DEC_LO + i] = timer_a_channel_oe_n_i[3 - i];
      end
    end
    // Port C: crystal pins are analog to the oscillator, never driven by a peripheral
    per_c_out  = '0;
    per_c_oe_n = '1;
    per_c_out[C_CAN_TX]  = can_tx_i;
    per_c_oe_n[C_CAN_TX] = 1'b0;
    per_c_out[C_TMR3]    = timer_c_channel_out_i[2];
    per_c_oe_n[C_TMR3]   = timer_c_channel_oe_n_i[2];
    per_c_out[C_TMR1]    = sel.c_sci0[0] ? 1'b0 : timer_c_channel_out_i[1];
    per_c_oe_n[C_TMR1]   = sel.c_sci0[0] ? 1'b1 : timer_c_channel_oe_n_i[1];
    per_c_out[C_TMR0]    = sel.c_sci0[1] ? serial_transmit_line_i : timer_c_channel_out_i[0];
    per_c_oe_n[C_TMR0]   = sel.c_sci0[1] ? 1'b0 : timer_c_channel_oe_n_i[0];

    // Port own logic wins where peripheral enable is cleared
    for (int i = 0; i < AW; i++)
    begin
      next_a_pin[i]  = a_cfg.per[i] ? per_a_out[i] : a_cfg.data[i];
      next_a_oe_n[i] = a_cfg.per[i] ? per_a_oe_n[i] : ~a_cfg.dir[i];
    end
    for (int i = 0; i < BW; i++)
    begin
      next_b_pin[i]  = b_cfg.per[i] ? per_b_out[i] : b_cfg.data[i];
      next_b_oe_n[i] = b_cfg.per[i] ? per_b_oe_n[i] : ~b_cfg.dir[i];
    end
    for (int i = 0; i < CW; i++)
    begin
      next_c_pin[i]  = c_cfg.per[i] ? per_c_out[i] : c_cfg.data[i];
      next_c_oe_n[i] = c_cfg.per[i] ? per_c_oe_n[i] : ~c_cfg.dir[i];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      a_pin_o      <= '0;
      a_pin_oe_n_o <= '1;
      b_pin_o      <= '0;
      b_pin_oe_n_o <= '1;
      c_pin_o      <= '0;
      c_pin_oe_n_o <= '1;
    end
    else
    begin
      a_pin_o      <= next_a_pin;
      a_pin_oe_n_o <= next_a_oe_n;
      b_pin_o      <= next_b_pin;
      b_pin_oe_n_o <= next_b_oe_n;
      c_pin_o      <= next_c_pin;
      c_pin_oe_n_o <= next_c_oe_n;
    end
  end

  // ******************************************************************
  // Synchronised pins to peripheral inputs (gated off when port owns it)
  // ******************************************************************
  always_comb
  begin
    pwm_fault_input_o     = a_sync[A_FAULT_LO +: 3] & a_cfg.per[A_FAULT_LO +: 3];
    current_sense_input_o = a_sync[A_SENSE_LO +: 3] & a_cfg.per[A_SENSE_LO +: 3];
    spi1_in_o             = a_sync[A_SPI1_LO +: 4] & a_cfg.per[A_SPI1_LO +: 4] & sel.a_spi1;
    spi0_in_o             = b_sync[B_SPI0_LO +: 4] & b_cfg.per[B_SPI0_LO +: 4];
    decoder_home_input_o    = b_sync[4] & b_cfg.per[4] & ~sel.b_timer_a;
    decoder_index_input_o   = b_sync[5] & b_cfg.per[5] & ~sel.b_timer_a;
    decoder_phase_b_input_o = b_sync[6] & b_cfg.per[6] & ~sel.b_timer_a;
    decoder_phase_a_input_o = b_sync[7] & b_cfg.per[7] & ~sel.b_timer_a;
    for (int i = 0; i < 4; i++)
    begin
      timer_a_channel_in_o[3 - i] = b_sync[B_DEC_LO + i] & b_cfg.per[B_DEC_LO + i]
                                    & sel.b_timer_a;
    end
    can_rx_o                = c_sync[C_CAN_RX] & c_cfg.per[C_CAN_RX];
    timer_c_channel_in_o[2] = c_sync[C_TMR3] & c_cfg.per[C_TMR3];
    timer_c_channel_in_o[1] = c_sync[C_TMR1] & c_cfg.per[C_TMR1] & ~sel.c_sci0[0];
    timer_c_channel_in_o[0] = c_sync[C_TMR0] & c_cfg.per[C_TMR0] & ~sel.c_sci0[1];
    serial_receive_line_o   = c_sync[C_TMR1] & c_cfg.per[C_TMR1] & sel.c_sci0[0];
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_gpio_write_c1;
    c_wr_i && !c_cfg_i.per[1];
  endsequence

  sequence s_serial_rx_chosen;
    c_cfg.per[C_TMR1] && sel.c_sci0[0];
  endsequence

  a_port_owns_a: assert property (!a_cfg.per[0] |=> a_pin_o[0] == $past(a_cfg.data[0]))
    else $error("port A bit 0 not driven by port data");
  a_pwm_route: assert property (a_cfg.per[1] |=> a_pin_o[1] == $past(pwm_output_line_i[1])
                                && !a_pin_oe_n_o[1])
    else $error("PWM line 1 not on pin");
  a_spi1_pick: assert property (a_cfg.per[4] && sel.a_spi1[2] |=>
                                a_pin_o[4] == $past(spi1_out_i[2]))
    else $error("SPI1 MOSI not selected");
  a_timer_a_map: assert property (b_cfg.per[4] && sel.b_timer_a |=>
                                  b_pin_o[4] == $past(timer_a_channel_out_i[3]))
    else $error("timer A ch3 not on port B bit 4");
  a_sci_tx_pick: assert property (c_cfg.per[6] && sel.c_sci0[1] |=>
                                  c_pin_o[6] == $past(serial_transmit_line_i))
    else $error("serial transmit not on port C bit 6");
  a_crystal_no_drive: assert property (c_cfg.per[C_CRYSTAL_IN] |=>
                                       c_pin_oe_n_o[C_CRYSTAL_IN])
    else $error("crystal pin driven");
  a_can_tx_route: assert property (c_cfg.per[3] |=> c_pin_o[3] == $past(can_tx_i))
    else $error("CAN transmit not on pin");
  a_fault_path: assert property (a_cfg.per[A_FAULT_LO] |->
                                 pwm_fault_input_o[0] == $past(a_pin_i[A_FAULT_LO], 2))
    else $error("fault input not passed");
  a_crystal_release: assert property (s_gpio_write_c1 |=>
                                      !crystal_enable_o && !c_cfg.per[C_CRYSTAL_OUT])
    else $error("crystal enable not dropped");
  a_gpio_dir_b: assert property (!b_cfg.per[0] |=>
                                 b_pin_oe_n_o[0] == !$past(b_cfg.dir[0]))
    else $error("port B bit 0 direction not applied");
  a_timer_a_in: assert property (b_cfg.per[B_DEC_LO] && sel.b_timer_a |->
                                 timer_a_channel_in_o[3] == $past(b_pin_i[B_DEC_LO], 2))
    else $error("timer A ch3 input not taken from pin");
  a_serial_rx_path: assert property (s_serial_rx_chosen |->
                                     serial_receive_line_o == $past(c_pin_i[C_TMR1], 2))
    else $error("serial receive not taken from pin");

endmodule
`default_nettype wire

/* File: testbench/periph_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ******************************************************************
// Peripheral-side model: registers each request so that every
// peripheral line changes just after a clock edge
// ******************************************************************
module periph_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [5:0] pwm_req_i,
  input  wire logic [3:0] spi1_req_i,
  input  wire logic [3:0] ta_req_i,
  input  wire logic [2:0] tc_req_i,
  input  wire logic [1:0] misc_req_i,
  output logic      [5:0] pwm_o,
  output logic      [3:0] spi1_out_o,
  output logic      [3:0] spi1_oe_n_o,
  output logic      [3:0] spi0_out_o,
  output logic      [3:0] spi0_oe_n_o,
  output logic      [3:0] ta_out_o,
  output logic      [3:0] ta_oe_n_o,
  output logic      [2:0] tc_out_o,
  output logic      [2:0] tc_oe_n_o,
  output logic            can_tx_o,
  output logic            sci_tx_o
);
  // SPI0 stays a listener so its pins never fight the bench
  assign spi0_out_o  = 4'h0;
  assign spi0_oe_n_o = 4'hF;
  assign spi1_oe_n_o = 4'h0;
  assign ta_oe_n_o   = 4'h0;
  assign tc_oe_n_o   = 3'h0;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pwm_o      <= 6'h00;
      spi1_out_o <= 4'h0;
      ta_out_o   <= 4'h0;
      tc_out_o   <= 3'h0;
      can_tx_o   <= 1'b0;
      sci_tx_o   <= 1'b0;
    end
    else
    begin
      pwm_o      <= pwm_req_i;
      spi1_out_o <= spi1_req_i;
      ta_out_o   <= ta_req_i;
      tc_out_o   <= tc_req_i;
      can_tx_o   <= misc_req_i[0];
      sci_tx_o   <= misc_req_i[1];
    end
  end
endmodule
`default_nettype wire

/* File: testbench/gpio_port_pin_sharing_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_port_pin_sharing_tb_top;
  import port_mux_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  port_a_cfg_t a_cfg = '0, a_cfg_rb;
  port_b_cfg_t b_cfg = '0, b_cfg_rb;
  port_c_cfg_t c_cfg = '0, c_cfg_rb;
  pin_sel_t    sel = '0, sel_rb;
  logic a_wr = 1'b0, b_wr = 1'b0, c_wr = 1'b0, sel_wr = 1'b0;
  logic [11:0] a_pin = 12'h000, a_out, a_oe_n, a_pu, a_in;
  logic [7:0]  b_pin = 8'h00, b_out, b_oe_n, b_pu, b_in;
  logic [6:0]  c_pin = 7'h00, c_out, c_oe_n, c_pu, c_in;
  logic [5:0]  pwm_req = 6'h00, pwm;
  logic [3:0]  spi1_req = 4'h0, ta_req = 4'h0;
  logic [2:0]  tc_req = 3'h0;
  logic [1:0]  misc_req = 2'h0;
  logic [3:0]  s1o, s1e, s0o, s0e, tao, tae, s1i, s0i, tai;
  logic [2:0]  tco, tce, flt, sns, tci;
  logic        cantx, scitx, home, idx, phb, pha, canrx, scirx, xen;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  periph_model model (.clk_i(clk), .rst_i(rst), .pwm_req_i(pwm_req), .spi1_req_i(spi1_req),
    .ta_req_i(ta_req), .tc_req_i(tc_req), .misc_req_i(misc_req), .pwm_o(pwm),
    .spi1_out_o(s1o), .spi1_oe_n_o(s1e), .spi0_out_o(s0o), .spi0_oe_n_o(s0e),
    .ta_out_o(tao), .ta_oe_n_o(tae), .tc_out_o(tco), .tc_oe_n_o(tce),
    .can_tx_o(cantx), .sci_tx_o(scitx));

  port_pin_mux dut (.clk_i(clk), .rst_i(rst), .a_cfg_i(a_cfg), .b_cfg_i(b_cfg),
    .c_cfg_i(c_cfg), .sel_i(sel), .a_wr_i(a_wr), .b_wr_i(b_wr), .c_wr_i(c_wr),
    .sel_wr_i(sel_wr), .a_cfg_o(a_cfg_rb), .b_cfg_o(b_cfg_rb), .c_cfg_o(c_cfg_rb),
    .sel_o(sel_rb), .a_in_o(a_in), .b_in_o(b_in), .c_in_o(c_in),
    .pwm_output_line_i(pwm), .spi1_out_i(s1o), .spi1_oe_n_i(s1e), .spi0_out_i(s0o),
    .spi0_oe_n_i(s0e), .timer_a_channel_out_i(tao), .timer_a_channel_oe_n_i(tae),
    .timer_c_channel_out_i(tco), .timer_c_channel_oe_n_i(tce), .can_tx_i(cantx),
    .serial_transmit_line_i(scitx), .pwm_fault_input_o(flt), .current_sense_input_o(sns),
    .spi1_in_o(s1i), .spi0_in_o(s0i), .decoder_home_input_o(home),
    .decoder_index_input_o(idx), .decoder_phase_b_input_o(phb),
    .decoder_phase_a_input_o(pha), .timer_a_channel_in_o(tai),
    .timer_c_channel_in_o(tci), .can_rx_o(canrx), .serial_receive_line_o(scirx),
    .crystal_enable_o(xen), .a_pin_i(a_pin), .b_pin_i(b_pin), .c_pin_i(c_pin),
    .a_pin_o(a_out), .a_pin_oe_n_o(a_oe_n), .a_pullup_o(a_pu), .b_pin_o(b_out),
    .b_pin_oe_n_o(b_oe_n), .b_pullup_o(b_pu), .c_pin_o(c_out), .c_pin_oe_n_o(c_oe_n),
    .c_pullup_o(c_pu));

  // ******************************************************************
  // Shared tasks
  // ******************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Each write is one cycle of strobe; the readback lands one edge later
  task automatic wr_sel(input pin_sel_t v);
    sel = v;
    sel_wr = 1'b1;
    step(1);
    sel_wr = 1'b0;
  endtask

  task automatic wr_ports(input port_a_cfg_t a, input port_b_cfg_t b, input port_c_cfg_t c);
    a_cfg = a;
    b_cfg = b;
    c_cfg = c;
    a_wr = 1'b1;
    b_wr = 1'b1;
    c_wr = 1'b1;
    step(1);
    a_wr = 1'b0;
    b_wr = 1'b0;
    c_wr = 1'b0;
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ******************************************************************
  // Hang guard: the sequence needs well under 200 cycles
  // ******************************************************************
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_count++;
      summarize();
    end
  end

  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    step(2);
    chk("port widths", 32'h000C_0807,
        {8'h00, 8'($bits(dut.a_in_o)), 8'($bits(dut.b_in_o)), 8'($bits(dut.c_in_o))});
    chk("a per reset", 32'hFFF, a_cfg_rb.per);
    chk("pullup resets", {5'h00, PORT_A_PUR_RESET, PORT_B_PUR_RESET, 7'h7C}, {a_pu, b_pu, c_pu});
    chk("c pullup reg", 32'h7C, c_cfg_rb.pur);
    chk("sel reset", 32'h0, sel_rb);
    chk("crystal enable", 32'h1, xen);
    // Port A inputs and PWM outputs on their default functions
    a_pin = 12'hB6D;
    pwm_req = 6'h2D;
    step(4);
    chk("fault inputs", {29'h0, a_pin[8:6]}, flt);
    chk("sense inputs", {29'h0, a_pin[11:9]}, sns);
    chk("pwm on pins", 32'h2D, a_out[5:0]);
    // Alternate SPI on bits 2 and 4 only, PWM kept on 3 and 5
    wr_sel('{a_spi1: 4'h5, c_sci0: 2'h0, b_timer_a: 1'b0});
    pwm_req = 6'h00;
    spi1_req = 4'hF;
    step(3);
    chk("sel readback", {25'h0, 4'h5, 3'h0}, sel_rb);
    chk("spi1 per pin", 32'h14, a_out[5:0]);
    chk("spi1 inputs", {28'h0, a_pin[5:2] & 4'h5}, s1i);
    // Port B default: SPI0 and decoder inputs
    b_pin = 8'h5C;
    step(4);
    chk("spi0 inputs", {28'h0, b_pin[3:0]}, s0i);
    chk("b pin sampled", {24'h0, b_pin}, b_in);
    chk("decoder inputs", {28'h0, b_pin[4], b_pin[5], b_pin[6], b_pin[7]}, {home, idx, phb, pha});
    chk("timer a idle", 32'h0, tai);
    wr_sel('{a_spi1: 4'h0, c_sci0: 2'h0, b_timer_a: 1'b1});
    ta_req = 4'h1;
    step(3);
    chk("timer a inputs", {28'h0, b_pin[4], b_pin[5], b_pin[6], b_pin[7]}, tai);
    chk("timer a ch0 out", 32'h8, b_out[7:4]);
    chk("decoder parked", 32'h0, {home, idx, phb, pha});
    // Port C: CAN and timer C, then the serial pair
    c_pin = 7'h35;
    tc_req = 3'h4;
    misc_req = 2'h1;
    step(4);
    chk("can rx", {31'h0, c_pin[2]}, canrx);
    chk("c pin sampled", {25'h0, c_pin}, c_in);
    chk("timer c inputs", {29'h0, c_pin[4], c_pin[5], c_pin[6]}, tci);
    chk("can tx and tc3", 32'h3, c_out[4:3]);
    wr_sel('{a_spi1: 4'h0, c_sci0: 2'h3, b_timer_a: 1'b0});
    tc_req = 3'h0;
    misc_req = 2'h2;
    step(3);
    chk("serial rx", {31'h0, c_pin[5]}, scirx);
    chk("serial tx", 32'h1, c_out[6]);
    chk("tc1 tc0 parked", 32'h0, tci[1:0]);
    // Hand pins to the port's own data and direction logic
    wr_ports('{data: 12'hA5C, dir: 12'hFFF, per: 12'h000, pur: 12'h0F0},
             '{data: 8'h05, dir: 8'h0F, per: 8'h00, pur: 8'h00},
             '{data: 7'h2A, dir: 7'h7F, per: 7'h7C, pur: 7'h7F});
    step(2);
    chk("a gpio drive", 32'hA5C, a_out);
    chk("a gpio enable", 32'h0, a_oe_n);
    chk("a pullup write", 32'h0F0, a_pu);
    chk("b gpio low nibble", {28'h0, 4'h5, 4'h0}, {b_out[3:0], b_oe_n[3:0]});
    chk("b inputs listen", 32'hF, b_oe_n[7:4]);
    chk("c bit0 gpio", 32'h0, c_oe_n[0]);
    chk("c crystal pins gpio", 32'h2, c_out[1:0]);
    chk("crystal released", 32'h0, xen);
    a_pin = 12'h3C5;
    step(4);
    chk("a pin sampled", 32'h3C5, a_in);
    summarize();
  end
endmodule
`default_nettype wire
